// ### include/ir_codec_pkg.sv
package ir_codec_pkg;
  // System clock rate assumed by all pulse timing
  localparam int unsigned CLK_HZ       = 4000000;
  localparam int unsigned CARRIER_HZ   = 38000;
  localparam int unsigned START_US     = 2400;
  localparam int unsigned ONE_US       = 1200;
  localparam int unsigned ZERO_US      = 600;
  localparam int unsigned GAP_US       = 600;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1000000;
  localparam logic [15:0] START_CYC    = 16'(START_US * CYC_PER_US);
  localparam logic [15:0] ONE_CYC      = 16'(ONE_US * CYC_PER_US);
  localparam logic [15:0] ZERO_CYC     = 16'(ZERO_US * CYC_PER_US);
  localparam logic [15:0] GAP_CYC      = 16'(GAP_US * CYC_PER_US);
  // Half carrier period, rounded down
  localparam logic [15:0] HALF_CAR_CYC = 16'(CLK_HZ / (2 * CARRIER_HZ));
  // Receive tolerance: 0.3 ms either side of nominal
  localparam logic [15:0] TOL_CYC      = 16'(300 * CYC_PER_US);
  // Decode threshold between a zero and a one (0.9 ms)
  localparam logic [15:0] MID_CYC      = 16'(900 * CYC_PER_US);
  // Gap longer than this ends any frame in progress (2 ms)
  localparam logic [15:0] IDLE_CYC     = 16'(2000 * CYC_PER_US);
  localparam int unsigned DATA_BITS    = 7;
  localparam int unsigned ID_BITS      = 5;
  localparam int unsigned FRAME_BITS   = DATA_BITS + ID_BITS;
  localparam logic [4:0]  RX_ID        = 5'h01;
  localparam logic [7:0]  DATA_MAX     = 8'h7f;
  localparam logic [6:0]  KEY_NONE     = 7'h00;
endpackage

// ### src/ir_pulse_meas.sv
`timescale 1ns/1ps
// Synchronises the demodulated input and measures mark/space lengths
module ir_pulse_meas (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        ir_in,
  output logic             mark_done,
  output logic             space_long,
  output logic [15:0]      mark_len
);
  logic [2:0]  sync_r, sync_nxt;
  logic        lvl_r, lvl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        done_r, done_nxt;
  logic        slong_r, slong_nxt;
  logic [15:0] len_r, len_nxt;

  // Level changes once stages two and three agree; receiver is active low
  always_comb begin
    sync_nxt  = {sync_r[1:0], ir_in};
    lvl_nxt   = lvl_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    slong_nxt = 1'b0;
    len_nxt   = len_r;
    if (sync_r[2] == sync_r[1] && sync_r[2] != lvl_r) begin
      lvl_nxt = sync_r[2];
      cnt_nxt = 16'h0000;
      if (!lvl_r) begin
        done_nxt = 1'b1;
        len_nxt  = cnt_r;
      end
    end else if (cnt_r != 16'hffff) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (lvl_r && cnt_r == ir_codec_pkg::IDLE_CYC)
      slong_nxt = 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_r  <= 3'h7;
      lvl_r   <= 1'b1;
      cnt_r   <= 16'h0000;
      done_r  <= 1'b0;
      slong_r <= 1'b0;
      len_r   <= 16'h0000;
    end else if (clk_en) begin
      sync_r  <= sync_nxt;
      lvl_r   <= lvl_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
      slong_r <= slong_nxt;
      len_r   <= len_nxt;
    end
  end

  assign mark_done  = done_r;
  assign space_long = slong_r;
  assign mark_len   = len_r;
endmodule

// ### src/ir_remote_pulse_codec.sv
`timescale 1ns/1ps
module ir_remote_pulse_codec (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        tx_req,
  input  wire logic [7:0]  tx_data,
  input  wire logic [7:0]  tx_id,
  output logic             tx_busy,
  output logic             tx_reject,
  output logic             gp_out0,
  input  wire logic        gp_in0,
  input  wire logic        rx_start,
  input  wire logic        legacy_mode,
  output logic             rx_wait,
  output logic             rx_valid,
  output logic [6:0]       rx_result
);
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_MARK = 2'b01, TX_GAP = 2'b11} tx_state_t;
  typedef enum logic [1:0] {RX_OFF = 2'b00, RX_HUNT = 2'b01, RX_BITS = 2'b11} rx_state_t;

  // Legacy key from command code, zero when not acknowledged
  function automatic logic [6:0] legacy_key(input logic [6:0] code);
    logic [6:0] k;
    k = ir_codec_pkg::KEY_NONE;
    if (code <= 7'h08)
      k = code + 7'h01;
    else
      unique case (code)
        7'h10:   k = 7'h0a;
        7'h09:   k = 7'h0b;
        7'h12:   k = 7'h0c;
        7'h11:   k = 7'h0d;
        7'h0c:   k = 7'h0e;
        7'h13:   k = 7'h0f;
        7'h14:   k = 7'h10;
        7'h15:   k = 7'h11;
        default: k = ir_codec_pkg::KEY_NONE;
      endcase
    return k;
  endfunction

  // Pulse length within tolerance of nominal
  function automatic logic in_tol(input logic [15:0] len, input logic [15:0] nom);
    return (len + ir_codec_pkg::TOL_CYC >= nom) && (len <= nom + ir_codec_pkg::TOL_CYC);
  endfunction

  tx_state_t   tx_st_r, tx_st_nxt;
  logic [11:0] tx_sh_r, tx_sh_nxt;
  logic [3:0]  tx_bit_r, tx_bit_nxt;
  logic        tx_first_r, tx_first_nxt;
  logic [15:0] tx_cnt_r, tx_cnt_nxt;
  logic [15:0] car_cnt_r, car_cnt_nxt;
  logic        car_r, car_nxt;
  logic        out_r, out_nxt;
  logic        busy_r, busy_nxt;
  logic        rej_r, rej_nxt;
  logic [15:0] mark_nom;

  // Current mark length: start pulse or bit pulse from LSB
  assign mark_nom = tx_first_r ? ir_codec_pkg::START_CYC :
                    (tx_sh_r[0] ? ir_codec_pkg::ONE_CYC : ir_codec_pkg::ZERO_CYC);

  // Transmit sequencer
  always_comb begin
    tx_st_nxt    = tx_st_r;
    tx_sh_nxt    = tx_sh_r;
    tx_bit_nxt   = tx_bit_r;
    tx_first_nxt = tx_first_r;
    tx_cnt_nxt   = tx_cnt_r;
    rej_nxt      = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (tx_req) begin
          if (tx_id == 8'h00 || tx_id > 8'h1f || tx_data > ir_codec_pkg::DATA_MAX) begin
            rej_nxt = 1'b1;
          end else begin
            tx_sh_nxt    = {tx_id[4:0], tx_data[6:0]};
            tx_bit_nxt   = 4'h0;
            tx_first_nxt = 1'b1;
            tx_cnt_nxt   = 16'h0001;
            tx_st_nxt    = TX_MARK;
          end
        end
      end
      TX_MARK: begin
        if (tx_cnt_r >= mark_nom) begin
          tx_cnt_nxt = 16'h0001;
          tx_st_nxt  = TX_GAP;
        end else begin
          tx_cnt_nxt = tx_cnt_r + 16'h0001;
        end
      end
      TX_GAP: begin
        if (tx_cnt_r >= ir_codec_pkg::GAP_CYC) begin
          tx_cnt_nxt = 16'h0001;
          if (tx_first_r) begin
            tx_first_nxt = 1'b0;
            tx_st_nxt    = TX_MARK;
          end else if (tx_bit_r == 4'(ir_codec_pkg::FRAME_BITS - 1)) begin
            tx_st_nxt = TX_IDLE;
          end else begin
            tx_sh_nxt  = {1'b0, tx_sh_r[11:1]};
            tx_bit_nxt = tx_bit_r + 4'h1;
            tx_st_nxt  = TX_MARK;
          end
        end else begin
          tx_cnt_nxt = tx_cnt_r + 16'h0001;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    busy_nxt = (tx_st_nxt != TX_IDLE);
  end

  // Carrier generator, phase restarts with each mark
  always_comb begin
    car_cnt_nxt = car_cnt_r;
    car_nxt     = car_r;
    if (tx_st_nxt != TX_MARK) begin
      car_cnt_nxt = 16'h0000;
      car_nxt     = 1'b1;
    end else if (car_cnt_r == ir_codec_pkg::HALF_CAR_CYC - 16'h0001) begin
      car_cnt_nxt = 16'h0000;
      car_nxt     = ~car_r;
    end else begin
      car_cnt_nxt = car_cnt_r + 16'h0001;
    end
    out_nxt = (tx_st_nxt == TX_MARK) && car_nxt;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_r    <= TX_IDLE;
      tx_sh_r    <= 12'h000;
      tx_bit_r   <= 4'h0;
      tx_first_r <= 1'b0;
      tx_cnt_r   <= 16'h0000;
      car_cnt_r  <= 16'h0000;
      car_r      <= 1'b1;
      out_r      <= 1'b0;
      busy_r     <= 1'b0;
      rej_r      <= 1'b0;
    end else if (clk_en) begin
      tx_st_r    <= tx_st_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_bit_r   <= tx_bit_nxt;
      tx_first_r <= tx_first_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      car_cnt_r  <= car_cnt_nxt;
      car_r      <= car_nxt;
      out_r      <= out_nxt;
      busy_r     <= busy_nxt;
      rej_r      <= rej_nxt;
    end
  end

  assign gp_out0   = out_r;
  assign tx_busy   = busy_r;
  assign tx_reject = rej_r;

  // Receive side
  logic        mk_done;
  logic        sp_long;
  logic [15:0] mk_len;

  ir_pulse_meas u_meas (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .ir_in      (gp_in0),
    .mark_done  (mk_done),
    .space_long (sp_long),
    .mark_len   (mk_len)
  );

  rx_state_t   rx_st_r, rx_st_nxt;
  logic [11:0] rx_sh_r, rx_sh_nxt;
  logic [3:0]  rx_bit_r, rx_bit_nxt;
  logic        rx_leg_r, rx_leg_nxt;
  logic        rx_wait_r, rx_wait_nxt;
  logic        rx_val_r, rx_val_nxt;
  logic [6:0]  rx_res_r, rx_res_nxt;
  logic [11:0] frame_w;
  logic [6:0]  key_w;

  assign frame_w = {mk_len > ir_codec_pkg::MID_CYC, rx_sh_r[11:1]};
  assign key_w   = legacy_key(frame_w[6:0]);

  // Receive sequencer: hunts a start pulse, then gathers twelve bits
  always_comb begin
    rx_st_nxt   = rx_st_r;
    rx_sh_nxt   = rx_sh_r;
    rx_bit_nxt  = rx_bit_r;
    rx_leg_nxt  = rx_leg_r;
    rx_val_nxt  = 1'b0;
    rx_res_nxt  = rx_res_r;
    unique case (rx_st_r)
      RX_OFF: begin
        if (rx_start) begin
          rx_leg_nxt = legacy_mode;
          rx_st_nxt  = RX_HUNT;
        end
      end
      RX_HUNT: begin
        if (mk_done && in_tol(mk_len, ir_codec_pkg::START_CYC)) begin
          rx_bit_nxt = 4'h0;
          rx_st_nxt  = RX_BITS;
        end
      end
      RX_BITS: begin
        if (sp_long) begin
          rx_st_nxt = RX_HUNT;
        end else if (mk_done) begin
          if (!in_tol(mk_len, ir_codec_pkg::ONE_CYC) && !in_tol(mk_len, ir_codec_pkg::ZERO_CYC)) begin
            rx_st_nxt = RX_HUNT;
          end else begin
            rx_sh_nxt  = frame_w;
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r == 4'(ir_codec_pkg::FRAME_BITS - 1)) begin
              rx_st_nxt = RX_HUNT;
              if (!rx_leg_r) begin
                rx_val_nxt = 1'b1;
                rx_res_nxt = frame_w[6:0];
                rx_st_nxt  = RX_OFF;
              end else if (key_w != ir_codec_pkg::KEY_NONE) begin
                rx_val_nxt = 1'b1;
                rx_res_nxt = key_w;
                rx_st_nxt  = RX_OFF;
              end
            end
          end
        end
      end
      default: rx_st_nxt = RX_OFF;
    endcase
    rx_wait_nxt = (rx_st_nxt != RX_OFF);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_r   <= RX_OFF;
      rx_sh_r   <= 12'h000;
      rx_bit_r  <= 4'h0;
      rx_leg_r  <= 1'b0;
      rx_wait_r <= 1'b0;
      rx_val_r  <= 1'b0;
      rx_res_r  <= 7'h00;
    end else if (clk_en) begin
      rx_st_r   <= rx_st_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_bit_r  <= rx_bit_nxt;
      rx_leg_r  <= rx_leg_nxt;
      rx_wait_r <= rx_wait_nxt;
      rx_val_r  <= rx_val_nxt;
      rx_res_r  <= rx_res_nxt;
    end
  end

  assign rx_wait   = rx_wait_r;
  assign rx_valid  = rx_val_r;
  assign rx_result = rx_res_r;
endmodule

// ### verif/ir_codec_chk.sv
`timescale 1ns/1ps
module ir_codec_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       tx_req,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] tx_id,
  input wire logic       tx_busy,
  input wire logic       tx_reject,
  input wire logic       gp_out0,
  input wire logic       gp_in0,
  input wire logic       rx_start,
  input wire logic       legacy_mode,
  input wire logic       rx_wait,
  input wire logic       rx_valid,
  input wire logic [6:0] rx_result
);
  logic        led_r;
  logic        led_nxt;
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  logic        bad_req;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Enabled cycles in the current LED level run; frozen cycles do not count
  always_comb begin
    led_nxt = gp_out0;
    run_nxt = run_r;
    if (gp_out0 != led_r)
      run_nxt = clk_en ? 16'h0001 : 16'h0000;
    else if (clk_en && run_r != 16'hffff)
      run_nxt = run_r + 16'h0001;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_r <= 1'b0;
      run_r <= 16'hffff;
    end else begin
      led_r <= led_nxt;
      run_r <= run_nxt;
    end
  end
  // Request that must be refused
  assign bad_req = (tx_id == 8'h00) || (tx_id > 8'h1f) || (tx_data > 8'h7f);
  a_reject_bad_req: assert property (tx_req && clk_en && !tx_busy && !$past(tx_busy) && bad_req
    |=> tx_reject && !tx_busy) else $error("bad request not refused");
  a_accept_good_req: assert property (tx_req && clk_en && !tx_busy && !$past(tx_busy) && !bad_req
    |=> tx_busy && gp_out0 && !tx_reject) else $error("good request not started");
  a_dark_when_idle: assert property (!tx_busy |-> !gp_out0) else $error("LED lit while idle");
  a_carrier_high_run: assert property ($fell(gp_out0) |-> run_r <= ir_codec_pkg::HALF_CAR_CYC)
    else $error("carrier high phase too long");
  a_carrier_low_run: assert property ($rose(gp_out0) && run_r < ir_codec_pkg::GAP_CYC
    |-> run_r == ir_codec_pkg::HALF_CAR_CYC) else $error("carrier low phase or gap wrong");
  a_reject_not_busy: assert property (tx_reject |-> !tx_busy) else $error("reject during frame");
  a_valid_one_cycle: assert property (rx_valid && clk_en |=> !rx_valid) else $error("result pulse too long");
  a_valid_ends_wait: assert property ($rose(rx_valid) |-> !rx_wait && $past(rx_wait))
    else $error("result without blocking receive");
  a_start_blocks: assert property (rx_start && clk_en && !rx_wait && !rx_valid |=> rx_wait)
    else $error("receive did not block");
  a_result_held: assert property (!rx_valid |-> $stable(rx_result)) else $error("result changed");
  c_reject: cover property (tx_reject);
  c_frame_end: cover property ($fell(tx_busy));
  c_result: cover property (rx_valid);
endmodule

// ### verif/ir_rx_module_model.sv
`timescale 1ns/1ps
// Receiver module: demodulates the LED carrier, output low while lit
module ir_rx_module_model (
  input  wire logic clk,
  input  wire logic led,
  output logic      demod_n
);
  int unsigned since = 1000;
  logic        led_q = 1'b0;
  // Carrier rise restarts the hold window
  always @(posedge clk) begin
    led_q <= led;
    since <= (led && !led_q) ? 0 : ((since < 1000) ? since + 1 : since);
  end
  // Output idles high, as a pulled-up receiver does
  assign demod_n = (since < 120) ? 1'b0 : 1'b1;
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       sys_rst;
  logic       clk_en;
  logic       tx_req;
  logic [7:0] tx_data;
  logic [7:0] tx_id;
  logic       tx_busy;
  logic       tx_reject;
  logic       gp_out0;
  logic       gp_in0;
  logic       rx_start;
  logic       legacy_mode;
  logic       rx_wait;
  logic       rx_valid;
  logic [6:0] rx_result;
  int         miscompares;
  int         total_checks;
  ir_remote_pulse_codec dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .tx_req(tx_req), .tx_data(tx_data),
    .tx_id(tx_id), .tx_busy(tx_busy), .tx_reject(tx_reject), .gp_out0(gp_out0), .gp_in0(gp_in0),
    .rx_start(rx_start), .legacy_mode(legacy_mode), .rx_wait(rx_wait), .rx_valid(rx_valid), .rx_result(rx_result));
  ir_rx_module_model ir_rx (.clk(clk), .led(gp_out0), .demod_n(gp_in0));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare a flag
  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Compare a value
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Advance n edges, then settle past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Out-of-range requests give only a reject pulse; frozen block does nothing
  task automatic t_reject();
    logic [7:0] ids [3] = '{8'h00, 8'h20, 8'h01};
    logic [7:0] dat [3] = '{8'h05, 8'h05, 8'h80};
    clk_en = 1'b0;
    tx_req = 1'b1;
    step(2);
    chk_bit("frozen tx_reject", 1'b0, tx_reject);
    clk_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      tx_id = ids[i];
      tx_data = dat[i];
      tx_req = 1'b1;
      step(1);
      tx_req = 1'b0;
      chk_bit("tx_reject", 1'b1, tx_reject);
      chk_bit("tx_busy", 1'b0, tx_busy);
      step(1);
      chk_bit("tx_reject end", 1'b0, tx_reject);
    end
    $display("test reject done");
  endtask
  // Send a frame to identifier 1 and receive it through the LED loop; rep holds the request for a resend
  task automatic t_loop(input logic [6:0] data, input logic legacy, input logic [6:0] exp, input logic rep);
    logic [11:0] bits;
    int          len;
    int          n;
    logic        seen;
    logic [6:0]  got;
    bits = {5'h01, data};
    len = ir_codec_pkg::START_CYC + ir_codec_pkg::GAP_CYC;
    for (int i = 0; i < 12; i++) begin
      len += (bits[i] ? ir_codec_pkg::ONE_CYC : ir_codec_pkg::ZERO_CYC) + ir_codec_pkg::GAP_CYC;
    end
    rx_start = 1'b1;
    legacy_mode = legacy;
    step(1);
    rx_start = 1'b0;
    chk_bit("rx_wait", 1'b1, rx_wait);
    tx_data = {1'b0, data};
    tx_id = 8'h01;
    tx_req = 1'b1;
    step(1);
    tx_req = rep;
    n = 0;
    seen = 1'b0;
    got = 7'h00;
    while (tx_busy === 1'b1 && n < 120000) begin
      n++;
      if (rx_valid === 1'b1) begin
        seen = 1'b1;
        got = rx_result;
      end
      step(1);
    end
    chk_val("busy cycles", len, n);
    chk_bit("rx_valid", 1'b1, seen);
    chk_val("rx_result", {25'h0, exp}, {25'h0, got});
    chk_bit("rx_wait end", 1'b0, rx_wait);
    // Held request resends the frame one idle cycle after the last gap
    if (rep) begin
      step(1);
      chk_bit("resend tx_busy", 1'b1, tx_busy);
      chk_bit("resend led", 1'b1, gp_out0);
      tx_req = 1'b0;
    end
    $display("test loop %h done", data);
  endtask
  // Freeze inside the resent start pulse splits it; receiver drops it; reset then cuts the frame
  task automatic t_cut();
    logic seen;
    seen = 1'b0;
    rx_start = 1'b1;
    legacy_mode = 1'b0;
    step(1);
    rx_start = 1'b0;
    step(3000);
    clk_en = 1'b0;
    step(200);
    chk_bit("frozen tx_busy", 1'b1, tx_busy);
    clk_en = 1'b1;
    for (int i = 0; i < 9000; i++) begin
      if (rx_valid === 1'b1)
        seen = 1'b1;
      step(1);
    end
    chk_bit("cut rx_valid", 1'b0, seen);
    chk_bit("cut rx_wait", 1'b1, rx_wait);
    sys_rst = 1'b1;
    #1;
    chk_bit("reset led", 1'b0, gp_out0);
    chk_bit("reset tx_busy", 1'b0, tx_busy);
    chk_bit("reset rx_wait", 1'b0, rx_wait);
    step(20);
    sys_rst = 1'b0;
    step(2);
    chk_bit("released led", 1'b0, gp_out0);
    chk_bit("released tx_busy", 1'b0, tx_busy);
    $display("test cut done");
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    tx_req = 1'b0;
    tx_data = 8'h00;
    tx_id = 8'h00;
    rx_start = 1'b0;
    legacy_mode = 1'b0;
    miscompares = 0;
    total_checks = 0;
    step(20);
    sys_rst = 1'b0;
    chk_bit("idle led", 1'b0, gp_out0);
    t_reject();
    t_loop(7'h45, 1'b0, 7'h45, 1'b0);
    t_loop(7'h09, 1'b1, 7'h0b, 1'b1);
    t_cut();
    end_sim();
  end
  // Watchdog
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
endmodule
bind ir_remote_pulse_codec ir_codec_chk chk (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .tx_req(tx_req),
  .tx_data(tx_data), .tx_id(tx_id), .tx_busy(tx_busy), .tx_reject(tx_reject), .gp_out0(gp_out0), .gp_in0(gp_in0),
  .rx_start(rx_start), .legacy_mode(legacy_mode), .rx_wait(rx_wait), .rx_valid(rx_valid), .rx_result(rx_result));
